// File: bench/pah_param_access_tb_top.sv
`timescale 1ns/1ps
`include "pah_defines.svh"
module pah_param_access_tb_top;
  localparam logic [7:0] RS = `PAH_SET_RAM;
  localparam logic [7:0] NS = `PAH_SET_NV;
  logic pclk;
  logic presetn;
  logic drive_running;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int failures;
  int checked;
  logic [15:0] vals [4] = '{16'h270f, 16'hfff0, 16'h2710, 16'hffff};
  logic [15:0] errs [4] = '{16'h0, 16'h0, 16'h8005, 16'h0};
  logic [15:0] lasts [4] = '{16'h270f, 16'hfff0, 16'hfff0, 16'hffff};
  logic [31:0] modes [5] = '{32'h8, 32'hb, 32'h5, 32'h2, 32'h2};
  logic [4:0] runs = 5'b01000;

  pah_param_access #(.AW(9)) u_dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_running(drive_running), .irq(irq));

  pah_prog_model u_prog (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input string what);
    u_prog.xfer(1'b0, a, 32'h0);
    check(u_prog.rd, exp, what);
    check({31'h0, u_prog.er}, 32'h0, "slverr");
  endtask

  task automatic acc(input logic [7:0] b, input logic [15:0] n,
      input logic [15:0] s, input logic [15:0] lo, input logic [15:0] hi,
      input logic [4:0] cmd, input int idx, input logic [15:0] err);
    u_prog.handshake(b, n, s, lo, hi, cmd, idx);
    check(u_prog.st_done & 32'h2f, 32'h20 | 32'h1 << idx, "done");
    check(u_prog.st_drop & 32'h2f, 32'h0, "release");
    rd(`PAH_OFF_ERR, {16'h0, err}, "error code");
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop();
  end

  initial begin
    failures = 0;
    checked = 0;
    presetn = 1'b0;
    drive_running = 1'b0;
    ce = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PAH_OFF_STAT, 32'h0, "status reset");
    rd(`PAH_OFF_ERR, 32'h0, "error reset");
    u_prog.xfer(1'b0, 8'h40, 32'h0);
    check({31'h0, u_prog.er}, 32'h1, "unmapped");
    check({31'h0, irq}, 32'h0, "irq idle");
    $display("test reset done");
    u_prog.xfer(1'b1, `PAH_OFF_MODE, 32'h9);
    for (int i = 0; i < 4; i++) begin
      acc(RS, 16'h5, 16'h0, vals[i], 16'h0, 5'h02, 1, errs[i]);
      acc(RS, 16'h5, 16'h0, 16'h0, 16'h0, 5'h01, 0, errs[i]);
      rd(RS + 8'h04, {16'h0, lasts[i]}, "content");
    end
    $display("test values done");
    for (int i = 0; i < 5; i++) begin
      u_prog.xfer(1'b1, `PAH_OFF_MODE, modes[i]);
      drive_running <= runs[i];
      acc(RS, 16'h5, 16'h0, 16'h0100 + 16'(i), 16'h0, 5'h02, 1,
        (i == 4) ? 16'h0 : 16'h8005);
      acc(RS, 16'h5, 16'h0, 16'h0, 16'h0, 5'h01, 0,
        (i == 4) ? 16'h0 : 16'h8005);
      rd(RS + 8'h04, (i == 4) ? 32'h0104 : 32'hffff, "kept");
    end
    drive_running <= 1'b0;
    $display("test modes done");
    acc(RS, 16'h012c, 16'h0, 16'h0, 16'h0, 5'h01, 0, 16'h812c);
    acc(NS, 16'h00f0, 16'h0, 16'habcd, 16'h0012, 5'h18, 3, 16'h0);
    acc(NS, 16'h00f0, 16'h0, 16'h0, 16'h0, 5'h04, 2, 16'h0);
    check({31'h0, u_prog.st_done[`PAH_STAT_DWRD]}, 32'h1, "dw");
    rd(NS + 8'h0c, 32'habcd, "dword low");
    rd(NS + 8'h10, 32'h0012, "dword high");
    acc(RS, 16'h00f0, 16'h0, 16'h1, 16'h1, 5'h02, 1, 16'h80f0);
    acc(RS, 16'h00f0, 16'h0, 16'h0, 16'h0, 5'h01, 0, 16'h80f0);
    rd(RS + 8'h0c, 32'habcd, "ram copy");
    $display("test two words done");
    acc(RS, 16'h0386, 16'h1, 16'h0055, 16'h0, 5'h02, 1, 16'h0);
    acc(RS, 16'h0386, 16'h2, 16'h0066, 16'h0, 5'h02, 1, 16'h0);
    acc(RS, 16'h0386, 16'h1, 16'h0, 16'h0, 5'h01, 0, 16'h0);
    rd(RS + 8'h04, 32'h0055, "calib item");
    acc(RS, 16'h03a7, 16'h3, 16'h0, 16'h0, 5'h01, 0, 16'h83a7);
    u_prog.xfer(1'b1, `PAH_OFF_ERR, 32'h1234);
    rd(`PAH_OFF_ERR, 32'h83a7, "error kept");
    u_prog.xfer(1'b1, `PAH_OFF_ERR, 32'h0);
    rd(`PAH_OFF_ERR, 32'h0, "error cleared");
    $display("test calibration done");
    rd(`PAH_OFF_IRQS, 32'h1f, "irq status");
    check({31'h0, irq}, 32'h0, "irq masked");
    u_prog.xfer(1'b1, `PAH_OFF_IRQM, 32'h1f);
    rd(`PAH_OFF_IRQM, 32'h1f, "irq mask");
    check({31'h0, irq}, 32'h1, "irq raised");
    u_prog.xfer(1'b1, `PAH_OFF_IRQS, 32'h0f);
    rd(`PAH_OFF_IRQS, 32'h10, "irq partial clear");
    check({31'h0, irq}, 32'h1, "irq held");
    u_prog.xfer(1'b1, `PAH_OFF_IRQS, 32'h10);
    rd(`PAH_OFF_IRQS, 32'h0, "irq cleared");
    check({31'h0, irq}, 32'h0, "irq low");
    $display("test interrupts done");
    ce <= 1'b0;
    fork
      rd(`PAH_OFF_IRQM, 32'h1f, "frozen read");
      begin
        repeat (6) @(posedge pclk);
        check({30'h0, psel, pready}, 32'h2, "ce freeze");
        ce <= 1'b1;
      end
    join
    $display("test clock enable done");
    report_and_stop();
  end
endmodule

// File: bench/pah_prog_model.sv
`timescale 1ns/1ps
`include "pah_defines.svh"
module pah_prog_model (
  input wire logic pclk, // Clock.
  output logic psel, // APB select.
  output logic penable, // APB enable.
  output logic pwrite, // APB direction.
  output logic [7:0] paddr, // APB byte address.
  output logic [31:0] pwdata, // APB write data.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr // APB error.
);
  logic [31:0] rd;
  logic er;
  logic [31:0] st_done;
  logic [31:0] st_drop;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Released address and data lines show the inverse of their last value.
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic handshake(input logic [7:0] b, input logic [15:0] n,
      input logic [15:0] s, input logic [15:0] lo, input logic [15:0] hi,
      input logic [4:0] cmd, input int idx);
    xfer(1'b1, b, {16'h0, n});
    xfer(1'b1, b + 8'h08, {16'h0, s});
    xfer(1'b1, b + 8'h04, {16'h0, lo});
    xfer(1'b1, b + 8'h0c, {16'h0, lo});
    xfer(1'b1, b + 8'h10, {16'h0, hi});
    xfer(1'b1, `PAH_OFF_CMD, {27'h0, cmd});
    do xfer(1'b0, `PAH_OFF_STAT, 32'h0); while (rd[idx] !== 1'b1);
    st_done = rd;
    xfer(1'b1, `PAH_OFF_CMD, 32'h0);
    xfer(1'b0, `PAH_OFF_STAT, 32'h0);
    st_drop = rd;
  endtask
endmodule

// File: hw/pah_access_chk.sv
`timescale 1ns/1ps
`include "pah_defines.svh"
module pah_access_chk #(
  parameter int AW = 9
) (
  input wire logic [15:0] num, // Parameter number.
  input wire logic [15:0] sel, // Calibration item select.
  input wire logic w, // Access is a write.
  input wire logic dflag, // Two-word write flag.
  input wire logic [15:0] vlo, // Value, low or only word.
  input wire logic [15:0] vhi, // Value, high word.
  input wire logic [1:0] opmode, // Operation mode.
  input wire logic [1:0] permit, // Write permission select.
  input wire logic running, // Drive is running.
  output logic ok, // Access may complete normally.
  output logic is_dw, // Parameter is two words wide.
  output logic is_cal, // Parameter is a calibration one.
  output logic [AW-1:0] addr, // Store address.
  output logic [31:0] value // Value to store.
);

  logic [15:0] cal_off;
  logic exists, mode_ok, range_ok;

  always_comb begin
    is_cal = num >= `PAH_CAL_FIRST && num <= `PAH_CAL_LAST;
    is_dw = num >= `PAH_DW_FIRST && num <= `PAH_DW_LAST;
    cal_off = num - `PAH_CAL_FIRST;
    exists = num <= `PAH_PLAIN_LAST || (is_cal && sel < `PAH_CAL_ITEMS);
    addr = is_cal ? AW'(`PAH_CAL_BASE) + AW'({cal_off[5:0], sel[1:0]})
                  : AW'(num[7:0]); // see RULE5
    mode_ok = (opmode == `PAH_MODE_PANEL || opmode == `PAH_MODE_COMMS) &&
              (permit == `PAH_PERMIT_ANY ||
               (permit == `PAH_PERMIT_STOPPED && !running)); // see RULE13
    range_ok = dflag || vlo <= `PAH_VAL_MAX ||
               vlo == `PAH_SPECIAL_8888 || vlo == `PAH_SPECIAL_9999;
    ok = exists && (!w || (mode_ok && range_ok && dflag == is_dw));
    value = dflag ? {vhi, vlo} : {16'h0000, vlo};
  end

endmodule

// File: hw/pah_param_access.sv
`timescale 1ns/1ps
`include "pah_defines.svh"
// Function
// RULE1 - Program loads number, then raises read command.
// RULE2 - Device loads content, then raises read completion.
// RULE3 - Two-word read fills low/high, sets flag.
// RULE4 - Separate register, command, completion sets per target.
// RULE5 - Calibration 902..935 item chosen by sub-select.
// RULE6 - Failed read loads error code number plus 8000h.
// RULE7 - Program loads number and value, raises write.
// RULE8 - Device raises write completion after processing write.
// RULE9 - Program sets two-word flag before write command.
// RULE10 - Normal write completion clears error code.
// RULE11 - Failed write completes, error code number plus 8000h.
// RULE12 - Failed write leaves stored value unchanged.
// RULE13 - Writes only in panel/comms mode, per permit.
// RULE14 - Program encodes 8888/9999 as fff0h/ffffh.
// RULE15 - Program drops write command after seeing completion.
// RULE16 - Completion drops only after command returns low.
// RULE17 - Read handshake releases like the write handshake.
module pah_param_access #(
  parameter int AW = 9
) (
  input wire logic pclk, // APB clock.
  input wire logic presetn, // APB reset, active low.
  input wire logic ce, // Clock enable, freezes all state.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error, unmapped address.
  input wire logic drive_running, // Drive is running.
  output logic irq // Interrupt, level, active high.
);

  pah_pkg::pah_state_s s, n;
  logic fire, wr_acc, ok, is_dw, is_cal, w, tg, mapped;
  logic [1:0] pick;
  logic [1:0] we;
  logic [AW-1:0] maddr;
  logic [31:0] wval, rval, rmux;
  logic [1:0][31:0] mrd;
  logic [15:0] rlo, errv;
  logic [2:0] f;

  function automatic logic [1:0] first_cmd(input logic [3:0] c);
    first_cmd = c[0] ? 2'h0 : c[1] ? 2'h1 : c[2] ? 2'h2 : 2'h3;
  endfunction

  function automatic logic [2:0] field_of(input logic [7:0] a,
                                          input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d < `PAH_SET_SPAN && d[1:0] == 2'h0) begin
      field_of = d[4:2];
    end else begin
      field_of = `PAH_F_NONE;
    end
  endfunction

  function automatic logic [7:0] set_base(input logic t);
    set_base = t ? `PAH_SET_NV : `PAH_SET_RAM;
  endfunction

  // Command bit order is {target, write}, so the pick indexes both.
  assign pick = first_cmd(s.cmd[3:0]);
  assign w = pick[0];
  assign tg = pick[1];
  assign fire = ce && s.st == pah_pkg::st_idle && |s.cmd[3:0]; // see RULE1

  pah_access_chk #(.AW(AW)) u_chk (
    .num(s.num[tg]),
    .sel(s.cal[tg]),
    .w(w),
    .dflag(s.cmd[`PAH_CMD_DWORD]),
    .vlo(s.cmd[`PAH_CMD_DWORD] ? s.dwl[tg] : s.cont[tg]),
    .vhi(s.dwh[tg]),
    .opmode(s.opmode),
    .permit(s.permit),
    .running(drive_running),
    .ok(ok),
    .is_dw(is_dw),
    .is_cal(is_cal),
    .addr(maddr),
    .value(wval)
  );

  // A write to the non-volatile store also refreshes the working copy.
  assign we[0] = fire && w && ok; // see RULE12
  assign we[1] = fire && w && ok && tg; // see RULE4

  generate
    if (AW < `PAH_MEM_AW_MIN) begin : g_bad_aw
      $error("AW too small for the calibration area");
    end
    for (genvar g = 0; g < 2; g++) begin : g_mem
      pah_param_mem #(.AW(AW)) u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .we(we[g]),
        .addr(maddr),
        .wdata(wval),
        .rdata(mrd[g])
      );
    end
  endgenerate

  assign rval = mrd[tg];
  assign rlo = rval[15:0];
  assign errv = s.num[tg] + `PAH_ERR_FLAG;

  // A register write lands at the edge that ends the access phase.
  assign wr_acc = ce && psel && penable && s.ack && pwrite;
  assign pready = ce && s.ack;
  assign prdata = s.rdata;
  // The error is qualified by ready, so a frozen bus never shows one.
  assign pslverr = pready && s.slverr;
  assign irq = |(s.isr & s.imr);

  always_comb begin
    rmux = '0;
    mapped = 1'b1;
    f = `PAH_F_NONE;
    case (paddr)
      `PAH_OFF_CMD: rmux[4:0] = s.cmd;
      `PAH_OFF_STAT: begin
        rmux[3:0] = s.done;
        rmux[`PAH_STAT_DWRD] = s.dwrd;
        rmux[`PAH_STAT_BUSY] = s.st == pah_pkg::st_hold;
      end
      `PAH_OFF_ERR: rmux[15:0] = s.err;
      `PAH_OFF_MODE: rmux[3:0] = {s.permit, s.opmode};
      `PAH_OFF_IRQS: rmux[4:0] = s.isr;
      `PAH_OFF_IRQM: rmux[4:0] = s.imr;
      default: begin
        mapped = 1'b0;
        for (int t = 0; t < 2; t++) begin
          f = field_of(paddr, set_base(t[0]));
          case (f)
            `PAH_F_NUM: rmux[15:0] = s.num[t];
            `PAH_F_CONT: rmux[15:0] = s.cont[t];
            `PAH_F_CAL: rmux[15:0] = s.cal[t];
            `PAH_F_DWL: rmux[15:0] = s.dwl[t];
            `PAH_F_DWH: rmux[15:0] = s.dwh[t];
            default: rmux = rmux;
          endcase
          if (f != `PAH_F_NONE) begin
            mapped = 1'b1;
          end
        end
      end
    endcase
  end

  always_comb begin
    n = s;
    // One wait state lets read data come from a flop.
    n.ack = psel && penable && !s.ack;
    if (psel && penable && !s.ack) begin
      n.rdata = rmux;
      n.slverr = !mapped;
    end
    if (wr_acc) begin
      for (int t = 0; t < 2; t++) begin
        case (field_of(paddr, set_base(t[0])))
          `PAH_F_NUM: n.num[t] = pwdata[15:0];
          `PAH_F_CONT: n.cont[t] = pwdata[15:0];
          `PAH_F_CAL: n.cal[t] = pwdata[15:0];
          `PAH_F_DWL: n.dwl[t] = pwdata[15:0];
          `PAH_F_DWH: n.dwh[t] = pwdata[15:0];
          default: n.num[t] = n.num[t];
        endcase
      end
      case (paddr)
        `PAH_OFF_CMD: n.cmd = pwdata[4:0];
        `PAH_OFF_ERR: begin
          if (pwdata[15:0] == 16'h0000) begin
            n.err = 16'h0000;
          end
        end
        `PAH_OFF_MODE: begin
          n.opmode = pwdata[1:0];
          n.permit = pwdata[3:2];
        end
        `PAH_OFF_IRQS: n.isr = s.isr & ~pwdata[4:0];
        `PAH_OFF_IRQM: n.imr = pwdata[4:0];
        default: n.cmd = n.cmd;
      endcase
    end
    // The handshake runs after the bus so that its loads win.
    case (s.st)
      pah_pkg::st_idle: begin
        if (fire) begin
          n.op = pick;
          n.done[pick] = 1'b1; // see RULE4 RULE8
          n.isr[pick] = 1'b1;
          n.st = pah_pkg::st_hold;
          if (!ok) begin
            n.err = errv; // see RULE6 RULE11
            n.isr[`PAH_IRQ_ERR] = 1'b1;
          end else if (w) begin
            n.err = 16'h0000; // see RULE10
          end else if (is_dw) begin
            n.dwl[tg] = rval[15:0]; // see RULE3
            n.dwh[tg] = rval[31:16];
            n.dwrd = 1'b1;
          end else begin
            n.cont[tg] = rlo; // see RULE2
            n.dwrd = 1'b0;
          end
        end
      end
      pah_pkg::st_hold: begin
        if (!s.cmd[s.op]) begin
          n.done = 4'h0; // see RULE16
          n.st = pah_pkg::st_idle; // see RULE17
        end
      end
      default: n.st = pah_pkg::st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Named steps of the command handshake.
  sequence fire_s;
    fire;
  endsequence
  sequence rd_ok_s;
    fire && !w && ok;
  endsequence
  sequence wr_ok_s;
    fire && w && ok;
  endsequence
  sequence wr_s;
    fire && w;
  endsequence
  sequence fail_s;
    fire && !ok;
  endsequence
  sequence hold_s;
    ce && s.st == pah_pkg::st_hold;
  endsequence

  AST_RD_LOAD: assert property ( // see RULE2
    rd_ok_s and !is_dw |=> s.cont[$past(tg)] == $past(rlo) &&
                           s.done[$past(pick)])
    else $error("read content or completion missing");

  AST_DW_READ: assert property ( // see RULE3
    rd_ok_s and is_dw |=> s.dwrd &&
      {s.dwh[$past(tg)], s.dwl[$past(tg)]} == $past(rval))
    else $error("two-word read not delivered");

  AST_ONE_DONE: assert property ( // see RULE4
    fire_s |=> s.done == (4'h1 << $past(pick)))
    else $error("wrong completion bit raised");

  AST_CAL_SEL: assert property ( // see RULE5
    fire && !w && is_cal && s.cal[tg] < `PAH_CAL_ITEMS |-> ok)
    else $error("valid calibration item refused");

  AST_ERR_CODE: assert property ( // see RULE6 see RULE11
    fail_s |=> s.err == $past(errv) && s.done[$past(pick)])
    else $error("error code or completion wrong on failure");

  AST_WR_CLEAN: assert property ( // see RULE10
    wr_ok_s |=> s.err == 16'h0000 && s.done[$past(pick)])
    else $error("normal write did not clear error code");

  AST_NO_STORE: assert property ( // see RULE12
    fail_s |-> we == 2'h0)
    else $error("store written on error completion");

  AST_MODE: assert property ( // see RULE13
    we[0] |-> (s.opmode == `PAH_MODE_PANEL ||
               s.opmode == `PAH_MODE_COMMS) &&
              (s.permit == `PAH_PERMIT_ANY ||
               (s.permit == `PAH_PERMIT_STOPPED && !drive_running)))
    else $error("write taken outside a write mode");

  AST_HOLD_DONE: assert property ( // see RULE16
    hold_s and s.cmd[s.op] |=> s.done[$past(s.op)] &&
                                s.st == pah_pkg::st_hold)
    else $error("completion dropped while command high");

  AST_RELEASE: assert property ( // see RULE17
    hold_s and !s.cmd[s.op] |=> s.done == 4'h0 &&
                                 s.st == pah_pkg::st_idle)
    else $error("completion not released after command low");

  // Every completion raises its event bit; a clear in the same cycle cannot undo it.
  AST_EVT_IRQ: assert property (
    fire_s |=> s.isr[$past(pick)])
    else $error("completion event not latched");

  AST_ERR_IRQ: assert property (
    fail_s |=> s.isr[`PAH_IRQ_ERR])
    else $error("error event not latched");

  // Every write, good or bad, ends in completion.
  AST_WR_DONE: assert property ( // see RULE8
    wr_s |=> s.done[$past(pick)] && s.st == pah_pkg::st_hold)
    else $error("write completion missing");

  AST_DONE_SOLE: assert property ( // see RULE4
    $onehot0(s.done))
    else $error("more than one completion bit set");

  AST_NV_COPY: assert property ( // see RULE4
    we[1] |-> we[0])
    else $error("store write skipped the working copy");

  AST_CAL_ADDR: assert property ( // see RULE5
    fire && is_cal && ok |-> maddr[1:0] == s.cal[tg][1:0])
    else $error("calibration item not selected");

  // A successful read must not disturb the error code.
  AST_RD_KEEP_ERR: assert property (
    rd_ok_s and !wr_acc |=> s.err == $past(s.err))
    else $error("read changed the error code");

  // The bus answers for one cycle per transfer.
  AST_ACK_PULSE: assert property (
    pready |=> !s.ack)
    else $error("ready held for more than one cycle");

  AST_SLVERR: assert property (
    pslverr |-> pready)
    else $error("error flagged without ready");

endmodule

// File: hw/pah_param_mem.sv
`timescale 1ns/1ps
module pah_param_mem #(
  parameter int AW = 9
) (
  input wire logic clk, // Clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic we, // Write strobe.
  input wire logic [AW-1:0] addr, // Word address.
  input wire logic [31:0] wdata, // Write data.
  output logic [31:0] rdata // Read data, combinational.
);

  logic [31:0] mem [1<<AW];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < (1 << AW); i++) begin
        mem[i] <= '0;
      end
    end else if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];

endmodule

// File: inc/pah_defines.svh
`ifndef PAH_DEFINES_SVH
`define PAH_DEFINES_SVH

// Register map, byte addresses.
`define PAH_SET_RAM 8'h00
`define PAH_SET_NV 8'h14
`define PAH_SET_SPAN 8'h14
`define PAH_F_NUM 3'h0
`define PAH_F_CONT 3'h1
`define PAH_F_CAL 3'h2
`define PAH_F_DWL 3'h3
`define PAH_F_DWH 3'h4
`define PAH_F_NONE 3'h7
`define PAH_OFF_CMD 8'h28
`define PAH_OFF_STAT 8'h2c
`define PAH_OFF_ERR 8'h30
`define PAH_OFF_MODE 8'h34
`define PAH_OFF_IRQS 8'h38
`define PAH_OFF_IRQM 8'h3c

// Field positions.
`define PAH_CMD_DWORD 4
`define PAH_STAT_DWRD 4
`define PAH_STAT_BUSY 5
`define PAH_IRQ_ERR 4

// Reset value of every register.
`define PAH_RST_VAL 16'h0000

// Parameter number space.
`define PAH_ERR_FLAG 16'h8000
`define PAH_PLAIN_LAST 16'h00ff
`define PAH_DW_FIRST 16'h00f0
`define PAH_DW_LAST 16'h00ff
`define PAH_CAL_FIRST 16'h0386
`define PAH_CAL_LAST 16'h03a7
`define PAH_CAL_ITEMS 16'h0003
`define PAH_CAL_BASE 9'h100
`define PAH_MEM_AW_MIN 9

// Value checks.
`define PAH_VAL_MAX 16'h270f
`define PAH_SPECIAL_8888 16'hfff0
`define PAH_SPECIAL_9999 16'hffff

// Operation modes and write permission codes.
`define PAH_MODE_PANEL 2'h1
`define PAH_MODE_COMMS 2'h2
`define PAH_PERMIT_STOPPED 2'h0
`define PAH_PERMIT_NONE 2'h1
`define PAH_PERMIT_ANY 2'h2

`endif

// File: inc/pah_pkg.sv
package pah_pkg;

  typedef enum logic {st_idle, st_hold} pah_state_e;

  typedef struct packed {
    pah_state_e st;
    logic [1:0] op;
    logic [1:0][15:0] num;
    logic [1:0][15:0] cont;
    logic [1:0][15:0] cal;
    logic [1:0][15:0] dwl;
    logic [1:0][15:0] dwh;
    logic [4:0] cmd;
    logic [3:0] done;
    logic dwrd;
    logic [15:0] err;
    logic [1:0] opmode;
    logic [1:0] permit;
    logic [4:0] isr;
    logic [4:0] imr;
    logic ack;
    logic [31:0] rdata;
    logic slverr;
  } pah_state_s;

endpackage
